/* src/fie_top.sv */
// Function
// RULE1: Critical value copied into recorded status
// RULE2: Corrected type field selects corrected class
// RULE3: Status CE encodings 10, 01, 11
// RULE4: Only advertised corrected encodings accepted
// RULE5: Injection state entered at countdown zero
// RULE6: Unconsumed-access injection fixed: always injected
// RULE7: Postponed enable gates deferred injection
// RULE8: Latent enable gates latent injection
// RULE9: Signaled enable gates recoverable injection
// RULE10: Unrecoverable enable gates unrecoverable injection
// RULE11: Containment enable gates uncontainable injection
// RULE12: Overrun value copied into recorded status
// RULE13: Fields unknown at cold, kept on recovery
// RULE14: Unsupported fields read zero, ignore writes
// RULE15: Counter decrements each tick while enabled
// RULE16: Enable write loads counter from reload
// RULE17: At zero stop or reload per restart
// RULE18: One class per event, fixed priority
`timescale 1ns/1ps
`default_nettype none
`include "fie_cfg.svh"

module fie_top
    import fie_pkg::*;
#(
    parameter logic [8:0] SUPPORT   = `FIE_SUPPORT_MASK,
    parameter logic [3:0] CE_PERMIT = `FIE_CE_PERMIT,
    parameter logic       RST_SUP   = `FIE_RESTART_SUP
) (
    input  wire logic         CLK,
    input  wire logic         RST_N,       // Cold reset
    input  wire logic         ERR_RST_N,   // Error recovery reset
    input  wire fie_pkg::fie_wr_t CTL_WR,  // Control register write
    input  wire logic         RLD_WR,      // Reload value write
    input  wire logic [31:0]  RLD_WDATA,   // Reload value data
    output logic [63:0]       CTL_RDATA,   // Control register read
    output logic [31:0]       RLD_RDATA,   // Reload value read
    output fie_pkg::fie_inject_t INJECT    // Injection report
);
    import fie_pkg::*;

    // All module state in one struct
    typedef struct packed {
        logic [8:0]  fields;     // Low control fields
        logic        restart;    // Restart control
        logic        cden;       // Countdown enable
        logic [31:0] reload;     // Reload value
        logic [63:0] rdata;      // Registered control read
        logic [31:0] rld_rdata;  // Registered reload read
        fie_inject_t inj;        // Registered report
    } fie_st_t;

    fie_st_t    st;          // Current state
    fie_st_t    next_st;     // Next state
    logic       hit;         // Countdown reached zero
    logic       load;        // Counter load strobe
    fie_class_t cls;         // Chosen class
    logic [8:0] wr_fields;   // Filtered written fields
    logic [1:0] wr_ce;       // Written corrected type

    // Counter sees the enable write directly
    assign load = CTL_WR.wr && CTL_WR.wdata[`FIE_CTL_CDEN_BIT];

    fie_counter #(.WIDTH(32)) u_cnt (
        .CLK     (CLK),
        .RST_N   (RST_N),
        .load    (load),
        .enable  (st.cden),
        .restart (st.restart),
        .reload  (st.reload),
        .hit     (hit)
    );

    fie_select u_sel (
        .ctl (st.fields),
        .cls (cls)
    );

    assign CTL_RDATA = st.rdata;
    assign RLD_RDATA = st.rld_rdata;
    assign INJECT    = st.inj;

    // Corrected-type encoding check against advertised set
    function automatic logic ce_ok(input logic [1:0] v);
        ce_ok = CE_PERMIT[v];
    endfunction

    // Status corrected-error encoding for a selection
    function automatic logic [1:0] ce_stat(input logic [1:0] sel);
        case (sel)
            2'h1:    ce_stat = `FIE_STAT_CE_NONSPEC;  // [RULE3]
            2'h2:    ce_stat = `FIE_STAT_CE_TRANS;    // [RULE3]
            2'h3:    ce_stat = `FIE_STAT_CE_PERSIST;  // [RULE3]
            default: ce_stat = 2'h0;
        endcase
    endfunction

    // Write filtering; a refused corrected type keeps the old one
    always_comb begin
        wr_ce = CTL_WR.wdata[`FIE_CTL_CORR_HI:`FIE_CTL_CORR_LO];
        if (!ce_ok(wr_ce)) begin
            wr_ce = st.fields[`FIE_CTL_CORR_HI:`FIE_CTL_CORR_LO]; // [RULE4]
        end
        wr_fields = CTL_WR.wdata[8:0];
        wr_fields[`FIE_CTL_CORR_HI:`FIE_CTL_CORR_LO] = wr_ce;
        wr_fields = wr_fields & SUPPORT;                        // [RULE14]
    end

    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.inj = '0;
        if (CTL_WR.wr) begin
            next_st.fields  = wr_fields;
            next_st.restart = CTL_WR.wdata[`FIE_CTL_RESTART_BIT] & RST_SUP;
            next_st.cden    = CTL_WR.wdata[`FIE_CTL_CDEN_BIT];  // [RULE16]
        end
        if (RLD_WR) begin
            next_st.reload = RLD_WDATA;
        end
        // Injection is spontaneous, no access needed, so never dropped
        if (hit && cls != FIE_CLS_NONE) begin                   // [RULE5] [RULE6]
            next_st.inj.valid = 1'b1;
            next_st.inj.cls   = cls;                            // [RULE18]
            next_st.inj.stat_ce = (cls == FIE_CLS_CORR) ?
                ce_stat(st.fields[`FIE_CTL_CORR_HI:`FIE_CTL_CORR_LO]) : 2'h0;
            next_st.inj.stat_crit  =
                st.fields[`FIE_CTL_CRIT_BIT] & SUPPORT[`FIE_CTL_CRIT_BIT]; // [RULE1]
            next_st.inj.stat_oflow =
                st.fields[`FIE_CTL_OFLOW_BIT] & SUPPORT[`FIE_CTL_OFLOW_BIT]; // [RULE12]
        end
        // Read view: reserved bits zero
        next_st.rdata = 64'h0;
        next_st.rdata[8:0] = next_st.fields & SUPPORT;          // [RULE14]
        next_st.rdata[`FIE_CTL_RESTART_BIT] = next_st.restart;
        next_st.rdata[`FIE_CTL_CDEN_BIT]    = next_st.cden;
        next_st.rld_rdata = next_st.reload;
    end

    // Cold reset clears all state; fields may hold any value then,
    // zero chosen. Recovery reset keeps all.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '0;                                           // [RULE13]
        end else begin
            st <= next_st;                                      // [RULE13]
        end
    end

    // Recovery reset has no effect on these fields by design
    logic unused_err_rst;
    assign unused_err_rst = ERR_RST_N;
endmodule

`default_nettype wire

/* src/fie_cfg.svh */
`ifndef FIE_CFG_SVH
`define FIE_CFG_SVH

// Field positions within the control word
`define FIE_CTL_OFLOW_BIT    0
`define FIE_CTL_CONTAIN_BIT  1
`define FIE_CTL_UNREC_BIT    2
`define FIE_CTL_SIGNAL_BIT   3
`define FIE_CTL_LATENT_BIT   4
`define FIE_CTL_POSTP_BIT    5
`define FIE_CTL_CORR_LO      6
`define FIE_CTL_CORR_HI      7
`define FIE_CTL_CRIT_BIT     8
`define FIE_CTL_RESTART_BIT  30
`define FIE_CTL_CDEN_BIT     31

// Default support mask for bits [8:0] and restart support
`define FIE_SUPPORT_MASK     9'h1FF
`define FIE_CE_PERMIT        4'hF
`define FIE_RESTART_SUP      1'b1

// Status corrected-error encodings
`define FIE_STAT_CE_NONSPEC  2'h2
`define FIE_STAT_CE_TRANS    2'h1
`define FIE_STAT_CE_PERSIST  2'h3

// Countdown tick divider (cycles per tick)
`define FIE_TICK_DIV         1

`endif

/* src/fie_pkg.sv */
package fie_pkg;

    // Injected error class
    typedef enum logic [2:0] {
        FIE_CLS_NONE,
        FIE_CLS_CONTAIN,
        FIE_CLS_UNREC,
        FIE_CLS_SIGNAL,
        FIE_CLS_LATENT,
        FIE_CLS_POSTP,
        FIE_CLS_CORR
    } fie_class_t;

    // Injection report to the recording logic
    typedef struct packed {
        logic       valid;      // One-cycle record pulse
        fie_class_t cls;        // Injected class
        logic [1:0] stat_ce;    // Status corrected-error field
        logic       stat_crit;  // Status critical flag
        logic       stat_oflow; // Status overflow flag
    } fie_inject_t;

    // Software write
    typedef struct packed {
        logic        wr;
        logic [63:0] wdata;
    } fie_wr_t;

endpackage

/* src/fie_counter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fie_cfg.svh"

module fie_counter #(
    parameter int WIDTH = 32
) (
    input  wire logic             CLK,
    input  wire logic             RST_N,
    input  wire logic             load,     // Load from reload value
    input  wire logic             enable,   // Counting enabled
    input  wire logic             restart,  // Reload at zero
    input  wire logic [WIDTH-1:0] reload,   // Reload value
    output logic                  hit       // Pulse on reaching zero
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic [7:0]       div;
        logic             hit;
    } fie_cnt_st_t;

    fie_cnt_st_t st;       // Current state
    fie_cnt_st_t next_st;  // Next state
    logic        tick;     // Countdown clock tick

    assign hit  = st.hit;
    assign tick = (st.div >= 8'(`FIE_TICK_DIV - 1));

    // Countdown logic
    always_comb begin
        next_st     = st;
        next_st.hit = 1'b0;
        next_st.div = tick ? 8'h00 : st.div + 8'h01;
        if (load) begin
            next_st.count = reload;                    // [RULE16]
            next_st.div   = 8'h00;
        end else if (enable && st.count != '0 && tick) begin
            next_st.count = st.count - WIDTH'(1);      // [RULE15]
            if (st.count == WIDTH'(1)) begin
                next_st.hit = 1'b1;                    // [RULE5]
                if (restart) begin
                    next_st.count = reload;            // [RULE17]
                end
            end
        end
    end

    // State register; count is zero only so that it starts idle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

`default_nettype wire

/* src/fie_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fie_cfg.svh"

module fie_select
    import fie_pkg::*;
(
    input  wire logic [8:0] ctl,   // Low control fields
    output fie_pkg::fie_class_t cls // Chosen class
);
    import fie_pkg::*;

    // Fixed priority: containment loss highest, corrected lowest
    always_comb begin
        cls = FIE_CLS_NONE;
        if (ctl[`FIE_CTL_CONTAIN_BIT]) begin
            cls = FIE_CLS_CONTAIN;                     // [RULE11] [RULE18]
        end else if (ctl[`FIE_CTL_UNREC_BIT]) begin
            cls = FIE_CLS_UNREC;                       // [RULE10]
        end else if (ctl[`FIE_CTL_SIGNAL_BIT]) begin
            cls = FIE_CLS_SIGNAL;                      // [RULE9]
        end else if (ctl[`FIE_CTL_LATENT_BIT]) begin
            cls = FIE_CLS_LATENT;                      // [RULE8]
        end else if (ctl[`FIE_CTL_POSTP_BIT]) begin
            cls = FIE_CLS_POSTP;                       // [RULE7]
        end else if (ctl[`FIE_CTL_CORR_HI:`FIE_CTL_CORR_LO] != 2'h0) begin
            cls = FIE_CLS_CORR;                        // [RULE2]
        end
    end
endmodule

`default_nettype wire

/* sim/fie_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fie_monitor
    import fie_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire logic                 ERR_RST_N,
    input  wire fie_pkg::fie_wr_t     CTL_WR,
    input  wire logic                 RLD_WR,
    input  wire logic [31:0]          RLD_WDATA,
    input  wire logic [63:0]          CTL_RDATA,
    input  wire logic [31:0]          RLD_RDATA,
    input  wire fie_pkg::fie_inject_t INJECT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    fie_class_t  want;       // Class expected by priority
    logic [1:0]  ce;         // Status code expected
    logic [63:0] prev_rdata; // Fields in force as the report formed
    // Report is formed one edge before it shows; judge it by the fields
    // of that cycle, so a write on the report's edge cannot mislead
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prev_rdata <= 64'h0;
        end else begin
            prev_rdata <= CTL_RDATA;
        end
    end
    // Lowest enable bit wins, corrected last
    always_comb begin
        casez (prev_rdata[7:1])
            7'b??????1: want = FIE_CLS_CONTAIN;
            7'b?????10: want = FIE_CLS_UNREC;
            7'b????100: want = FIE_CLS_SIGNAL;
            7'b???1000: want = FIE_CLS_LATENT;
            7'b??10000: want = FIE_CLS_POSTP;
            7'b0000000: want = FIE_CLS_NONE;
            default:    want = FIE_CLS_CORR;
        endcase
        ce = (prev_rdata[7:6] == 2'h1) ? 2'h2 :
             (prev_rdata[7:6] == 2'h2) ? 2'h1 : prev_rdata[7:6];
    end
    // Countdown started from a reload of three with a class enabled
    sequence s_load3;
        CTL_WR.wr && CTL_WR.wdata[31] && CTL_WR.wdata[7:1] != 7'h0
            && RLD_RDATA == 32'h3;
    endsequence
    a_ctl_readback: assert property (CTL_WR.wr |=> CTL_RDATA[31:0] ==
        ($past(CTL_WR.wdata[31:0]) & 32'hC00001FF)) else $error("ctl readback");
    a_rsvd_zero: assert property (CTL_RDATA[63:32] == 32'h0
        && CTL_RDATA[29:9] == 21'h0) else $error("reserved bits set");
    a_rld_readback: assert property (RLD_WR |=>
        RLD_RDATA == $past(RLD_WDATA)) else $error("reload readback");
    a_one_class: assert property (INJECT.valid |-> INJECT.cls == want
        && want != FIE_CLS_NONE) else $error("wrong class");
    a_ce_code: assert property (INJECT.valid && INJECT.cls == FIE_CLS_CORR
        |-> INJECT.stat_ce == ce) else $error("wrong ce code");
    a_crit_copy: assert property (INJECT.valid |->
        INJECT.stat_crit == prev_rdata[8]) else $error("crit not copied");
    a_oflow_copy: assert property (INJECT.valid |->
        INJECT.stat_oflow == prev_rdata[0]) else $error("oflow not copied");
    a_zero_delay: assert property (s_load3 |=>
        !INJECT.valid [*4] ##1 INJECT.valid) else $error("inject timing");
    a_recov_keep: assert property (!ERR_RST_N && !CTL_WR.wr |=>
        $stable(CTL_RDATA)) else $error("lost on recovery");
endmodule
bind fie_top fie_monitor i_mon (.CLK(CLK), .RST_N(RST_N),
    .ERR_RST_N(ERR_RST_N), .CTL_WR(CTL_WR), .RLD_WR(RLD_WR),
    .RLD_WDATA(RLD_WDATA), .CTL_RDATA(CTL_RDATA),
    .RLD_RDATA(RLD_RDATA), .INJECT(INJECT));
`default_nettype wire

/* sim/fie_recorder.sv */
`timescale 1ns/1ps
`default_nettype none
module fie_recorder
    import fie_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire fie_pkg::fie_inject_t INJECT,
    output fie_pkg::fie_inject_t      rec,  // Last recorded report
    output logic [7:0]                cnt   // Events recorded
);
    // Status capture, as the recording side sees it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rec <= '0;
            cnt <= 8'h0;
        end else if (INJECT.valid) begin
            rec <= INJECT;
            cnt <= cnt + 8'h1;
        end
    end
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fie_pkg::*;
    logic CLK = 0;
    logic RST_N = 0;
    logic ERR_RST_N = 1;
    fie_wr_t CTL_WR = '0;
    logic RLD_WR = 0;
    logic [31:0] RLD_WDATA = 32'h0;
    logic [63:0] CTL_RDATA;
    logic [31:0] RLD_RDATA;
    fie_inject_t INJECT, rec;
    logic [7:0] cnt, c0;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    always #5 CLK = ~CLK;
    fie_top i_dut (.CLK(CLK), .RST_N(RST_N), .ERR_RST_N(ERR_RST_N),
        .CTL_WR(CTL_WR), .RLD_WR(RLD_WR), .RLD_WDATA(RLD_WDATA),
        .CTL_RDATA(CTL_RDATA), .RLD_RDATA(RLD_RDATA), .INJECT(INJECT));
    fie_recorder i_rec (.CLK(CLK), .RST_N(RST_N), .INJECT(INJECT),
        .rec(rec), .cnt(cnt));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // One-cycle strobes launched off the falling edge
    task wr_ctl(input logic [63:0] d);
        @(negedge CLK);
        CTL_WR = {1'b1, d};
        @(negedge CLK);
        CTL_WR.wr = 1'b0;
    endtask
    task wr_rld(input logic [31:0] d);
        @(negedge CLK);
        RLD_WR = 1'b1;
        RLD_WDATA = d;
        @(negedge CLK);
        RLD_WR = 1'b0;
    endtask
    // Start with reload three, expect exactly one report
    task run_inj(input logic [8:0] c, input fie_class_t k, input logic [1:0] e);
        c0 = cnt;
        wr_rld(32'h3);
        wr_ctl({32'h0, 1'b1, 22'h0, c});
        repeat (10) @(negedge CLK);
        chk(cnt, c0 + 8'h1);
        chk({rec.cls, rec.stat_crit, rec.stat_oflow}, {k, c[8], c[0]});
        if (k == FIE_CLS_CORR) chk(rec.stat_ce, e);
    endtask
    task t_classes;
        run_inj(9'h002, FIE_CLS_CONTAIN, 2'h0);
        run_inj(9'h004, FIE_CLS_UNREC, 2'h0);
        run_inj(9'h108, FIE_CLS_SIGNAL, 2'h0);
        run_inj(9'h011, FIE_CLS_LATENT, 2'h0);
        run_inj(9'h020, FIE_CLS_POSTP, 2'h0);
        run_inj(9'h040, FIE_CLS_CORR, 2'h2);
        run_inj(9'h080, FIE_CLS_CORR, 2'h1);
        run_inj(9'h1C1, FIE_CLS_CORR, 2'h3);
        run_inj(9'h0FE, FIE_CLS_CONTAIN, 2'h0);
        run_inj(9'h0F0, FIE_CLS_LATENT, 2'h0);
        $display("test classes done");
    endtask
    // Reserved space and readback of every writable control bit and reload bits [15:0]
    task t_regs;
        wr_rld(32'hFFFF);
        wr_ctl({64{1'b1}});
        @(negedge CLK);
        chk(CTL_RDATA, 64'h00000000C00001FF);
        chk(64'(RLD_RDATA), 64'hFFFF);
        wr_ctl(64'h0);
        $display("test regs done");
    endtask
    // Flags only, no class: countdown runs out silently
    task t_none;
        c0 = cnt;
        wr_rld(32'h3);
        wr_ctl(64'h80000101);
        repeat (10) @(negedge CLK);
        chk(cnt, c0);
        $display("test none done");
    endtask
    // Restart keeps firing until disabled
    task t_restart;
        c0 = cnt;
        wr_rld(32'h2);
        wr_ctl(64'hC0000004);
        repeat (16) @(negedge CLK);
        wr_ctl(64'h0);
        chk(cnt - c0 >= 8'h3, 64'h1);
        c0 = cnt;
        repeat (10) @(negedge CLK);
        chk(cnt, c0);
        $display("test restart done");
    endtask
    task t_errrst;
        wr_ctl(64'h155);
        ERR_RST_N = 1'b0;
        repeat (3) @(negedge CLK);
        ERR_RST_N = 1'b1;
        chk(CTL_RDATA, 64'h155);
        $display("test recovery done");
    endtask
    initial begin
        repeat (3) @(negedge CLK);
        RST_N = 1'b1;
        chk(CTL_RDATA, 64'h0);
        chk(64'(INJECT), 64'h0);
        t_regs();
        t_classes();
        t_none();
        t_restart();
        t_errrst();
        give_verdict();
    end
endmodule
`default_nettype wire
